// ==== design/ahp_map.svh ====
// Notes on behaviour
// [R1] data bus driven only while chip select and read strobe are both low
// [R2] byte select high gives upper byte, low gives lower byte
// [R3] result is 12 bits, right justified, lower byte holds bits 7..0
// [R4] upper byte: status on bit 7, zeros on 6..4, result 11..8 on 3..0
// [R5] write strobe low with chip select low starts a new conversion
// [R6] internal oscillator: host needs only a short write strobe
// [R7] external clock: host holds strobe, select and address over auto-zero
// [R8] busy output low during conversion, high otherwise
// [R9] status flag reads high while converting, low when done
// [R10] channel address captured on rising edge of write strobe
// [R11] address decode: high bit first, 00..11 pick channels 0..3
// [R12] internal oscillator conversion with auto-zero takes about 120 us; default AZ_CYC and OSC_DIV give about 60 us at 25 MHz
// [R13] external clock: write strobe held low at least 10 us
// [R14] msb decided on second falling conversion clock edge after strobe rises; internal mode counts falls only after the AZ_CYC auto-zero
// [R15] read during conversion returns partial approximation register
// [R16] write during conversion abandons it and restarts
// [R17] twelve clock periods of approximation msb first, then result and busy
// [R18] host reads both bytes in either order after completion
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH
`define AHP_RES_W 12
`define AHP_BITS_W 4
`define AHP_LAST_BIT 4'h0
`define AHP_MSB_FALL 2'h1
`define AHP_FIRST_BIT 4'hb
`define AHP_CLK_HZ 25000000
`define AHP_AZ_US 10
`define AHP_CONV_US 120
`define AHP_AZ_CYC ((`AHP_CLK_HZ / 1000000) * `AHP_AZ_US)
`define AHP_CONV_CYC ((`AHP_CLK_HZ / 1000000) * `AHP_CONV_US)
`endif

// ==== design/ahp_pkg.sv ====
package ahp_pkg;
	typedef enum logic [3:0] {
		AHP_IDLE = 4'h1,
		AHP_ZERO = 4'h2,
		AHP_SYNC = 4'h4,
		AHP_APPR = 4'h8
	} ahp_state_t;
endpackage

// ==== design/ahp_conv_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface ahp_conv_if;
	logic tick;
	logic fall;
	modport src (output tick, output fall);
	modport snk (input tick, input fall);
endinterface
`default_nettype wire

// ==== design/ahp_osc.sv ====
`timescale 1ns/10ps
`default_nettype none
// conversion clock: internal rc emulation by divider, or external pin
module ahp_osc #(
	parameter int DIV = 50
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ext_mode_in,
	input wire logic ext_clk_in,
	ahp_conv_if.src cv
);
	typedef struct packed {
		logic [15:0] cnt;
		logic ph;
		logic prev;
		logic fall;
	} ahp_osc_st_t;
	ahp_osc_st_t st_ff, nxt_st;
	logic src_lvl;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnt = st_ff.cnt + 16'h0001;
		if (st_ff.cnt >= 16'(DIV - 1)) begin
			nxt_st.cnt = 16'h0000;
			nxt_st.ph = ~st_ff.ph;
		end
		src_lvl = ext_mode_in ? ext_clk_in : st_ff.ph;
		nxt_st.prev = src_lvl;
		nxt_st.fall = st_ff.prev & ~src_lvl;
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign cv.fall = st_ff.fall;
	assign cv.tick = st_ff.fall;
endmodule
`default_nettype wire

// ==== design/ahp_sar.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ahp_map.svh"
// successive approximation register, one bit per falling conversion edge
module ahp_sar #(
	parameter int W = `AHP_RES_W
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic clr_in,
	input wire logic step_in,
	input wire logic [`AHP_BITS_W-1:0] bit_in,
	input wire logic keep_in,
	output logic [W-1:0] sar_out
);
	typedef struct packed {
		logic [W-1:0] sar;
	} ahp_sar_st_t;
	ahp_sar_st_t st_ff, nxt_st;
	always_comb begin
		nxt_st = st_ff;
		if (clr_in) begin
			nxt_st.sar = '0;
		end else if (step_in) begin
			nxt_st.sar[bit_in] = keep_in; // [R17]
			if (bit_in != '0) begin
				nxt_st.sar[bit_in - 1'b1] = 1'b1;
			end
		end
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign sar_out = st_ff.sar;
endmodule
`default_nettype wire

// ==== design/ahp_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ahp_map.svh"
module ahp_top #(
	parameter int AZ_CYC = `AHP_AZ_CYC,
	parameter int OSC_DIV = 50
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic cs_n_in,
	input wire logic wr_n_in,
	input wire logic rd_n_in,
	input wire logic byte_half_select_in,
	input wire logic channel_addr_lo_in,
	input wire logic channel_addr_hi_in,
	input wire logic ext_clk_mode_in,
	input wire logic ext_clk_in,
	input wire logic cmp_hi_in,
	output logic [7:0] data_out_bus_out,
	output logic [7:0] data_out_bus_oe_n_out,
	output logic busy_n_out,
	output logic [1:0] channel_sel_out
);
	typedef struct packed {
		ahp_pkg::ahp_state_t st;
		logic [15:0] az_cnt;
		logic [1:0] falls;
		logic [`AHP_BITS_W-1:0] bitn;
		logic wr_prev;
		logic [1:0] chan;
		logic [`AHP_RES_W-1:0] res;
		logic [7:0] dout;
		logic [7:0] oe_n;
		logic busy_n;
	} ahp_st_t;
	ahp_st_t st_ff, nxt_st;
	ahp_conv_if cv();
	logic sar_clr;
	logic sar_step;
	logic [`AHP_RES_W-1:0] sar;
	logic wr_act;
	logic wr_rise;
	logic [`AHP_RES_W-1:0] src;
	ahp_osc #(.DIV(OSC_DIV)) u_osc (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ext_mode_in(ext_clk_mode_in),
		.ext_clk_in(ext_clk_in),
		.cv(cv)
	);
	ahp_sar #(.W(`AHP_RES_W)) u_sar (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.clr_in(sar_clr),
		.step_in(sar_step),
		.bit_in(st_ff.bitn),
		.keep_in(cmp_hi_in),
		.sar_out(sar)
	);
	always_comb begin
		nxt_st = st_ff;
		wr_act = ~cs_n_in & ~wr_n_in; // [R5]
		wr_rise = st_ff.wr_prev & ~wr_act;
		nxt_st.wr_prev = wr_act;
		sar_clr = 1'b0;
		sar_step = 1'b0;
		case (st_ff.st)
			ahp_pkg::AHP_IDLE: begin
			end
			ahp_pkg::AHP_ZERO: begin
				// internal mode times auto-zero itself after strobe rises
				if (!wr_act && !ext_clk_mode_in &&
					st_ff.az_cnt < 16'(AZ_CYC)) begin // [R6] [R12]
					nxt_st.az_cnt = st_ff.az_cnt + 16'h0001;
				end
				// external mode relies on host holding the strobe
				if (!wr_act && (ext_clk_mode_in ||
					st_ff.az_cnt >= 16'(AZ_CYC))) begin // [R7] [R13]
					nxt_st.st = ahp_pkg::AHP_SYNC;
					nxt_st.falls = 2'h0;
				end
			end
			ahp_pkg::AHP_SYNC: begin
				if (cv.fall) begin
					nxt_st.falls = st_ff.falls + 2'h1;
					if (st_ff.falls == `AHP_MSB_FALL) begin // [R14]
						sar_step = 1'b1;
						nxt_st.bitn = st_ff.bitn - 4'h1;
						nxt_st.st = ahp_pkg::AHP_APPR;
					end
				end
			end
			ahp_pkg::AHP_APPR: begin
				if (cv.fall) begin
					sar_step = 1'b1; // [R17]
					nxt_st.bitn = st_ff.bitn - 4'h1;
					if (st_ff.bitn == `AHP_LAST_BIT) begin
						nxt_st.st = ahp_pkg::AHP_IDLE;
						nxt_st.busy_n = 1'b1; // [R8]
						nxt_st.res = {sar[`AHP_RES_W-1:1], cmp_hi_in};
					end
				end
			end
			default: begin
				nxt_st.st = ahp_pkg::AHP_IDLE;
			end
		endcase
		if (wr_act) begin
			// new strobe abandons any running conversion
			nxt_st.st = ahp_pkg::AHP_ZERO; // [R16]
			nxt_st.busy_n = 1'b0; // [R8]
			nxt_st.az_cnt = 16'h0000;
			nxt_st.bitn = `AHP_FIRST_BIT;
			sar_clr = 1'b1;
		end
		if (wr_rise) begin
			nxt_st.chan = {channel_addr_hi_in, channel_addr_lo_in}; // [R10] [R11]
		end
		src = st_ff.busy_n ? st_ff.res : sar; // [R15]
		if (byte_half_select_in) begin // [R2]
			nxt_st.dout = {~st_ff.busy_n, 3'h0, src[11:8]}; // [R4] [R9]
		end else begin
			nxt_st.dout = src[7:0]; // [R3]
		end
		nxt_st.oe_n = {8{~(~cs_n_in & ~rd_n_in)}}; // [R1]
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
			st_ff.st <= ahp_pkg::AHP_IDLE;
			st_ff.oe_n <= 8'hff;
			st_ff.busy_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign data_out_bus_out = st_ff.dout;
	assign data_out_bus_oe_n_out = st_ff.oe_n;
	assign busy_n_out = st_ff.busy_n;
	assign channel_sel_out = st_ff.chan;

	chk_bus_drive: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(!cs_n_in && !rd_n_in) |=> data_out_bus_oe_n_out == 8'h00) // [R1]
		else $error("bus not driven during read");
	chk_bus_float: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(cs_n_in || rd_n_in) |=> data_out_bus_oe_n_out == 8'hff) // [R1]
		else $error("bus driven outside read");
	chk_upper_zeros: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		byte_half_select_in |=> data_out_bus_out[6:4] == 3'h0) // [R4]
		else $error("upper byte bits 6..4 not zero");
	chk_status_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		byte_half_select_in |=> data_out_bus_out[7] == ~$past(busy_n_out)) // [R9]
		else $error("status flag wrong");
	chk_start_busy: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(!cs_n_in && !wr_n_in) |=> !busy_n_out) // [R5]
		else $error("busy not low after start");
	chk_restart_state: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(!cs_n_in && !wr_n_in) |=> st_ff.st == ahp_pkg::AHP_ZERO) // [R16]
		else $error("conversion not restarted");
	chk_addr_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		wr_rise |=> channel_sel_out ==
		$past({channel_addr_hi_in, channel_addr_lo_in})) // [R10]
		else $error("channel address not latched");
	chk_done_busy: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(st_ff.st == ahp_pkg::AHP_APPR && cv.fall && st_ff.bitn == 4'h0
		&& wr_n_in) |=> busy_n_out) // [R17]
		else $error("busy not released at end");
	chk_lower_byte: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(!byte_half_select_in && busy_n_out) |=>
		data_out_bus_out == $past(st_ff.res[7:0])) // [R3]
		else $error("lower byte wrong");
	cov_start: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		$fell(busy_n_out));
	cov_done: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(busy_n_out));
	cov_restart: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		st_ff.st == ahp_pkg::AHP_APPR && !cs_n_in && !wr_n_in);
	cov_read_hi: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		!cs_n_in && !rd_n_in && byte_half_select_in);
endmodule
`default_nettype wire

// ==== verification/ahp_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// host processor model; it changes pins only on the falling edge
module ahp_host (
	input wire logic mclk_in,
	input wire logic [7:0] bus_in,
	input wire logic [7:0] oe_n_in,
	output logic cs_n_out,
	output logic wr_n_out,
	output logic rd_n_out,
	output logic byte_half_select_out,
	output logic a_lo_out,
	output logic a_hi_out
);
	initial begin
		{cs_n_out, wr_n_out, rd_n_out} = 3'h7;
		{byte_half_select_out, a_lo_out, a_hi_out} = 3'h0;
	end
	// hold is the strobe length; external mode needs it past auto-zero
	task automatic conv(input logic [1:0] ch, input int hold);
		@(negedge mclk_in);
		{a_hi_out, a_lo_out} = ch;
		{cs_n_out, wr_n_out} = 2'h0;
		repeat (hold) @(negedge mclk_in);
		// address is left as is until the next start
		{cs_n_out, wr_n_out} = 2'h3;
	endtask
	// one byte per call; the caller issues both halves
	task automatic rd(input logic bs, output logic [7:0] d,
		output logic [7:0] oe, output logic [7:0] idle);
		@(negedge mclk_in);
		byte_half_select_out = bs;
		{cs_n_out, rd_n_out} = 2'h0;
		@(negedge mclk_in);
		d = bus_in;
		oe = oe_n_in;
		{cs_n_out, rd_n_out} = 2'h3;
		@(negedge mclk_in);
		idle = oe_n_in;
	endtask
endmodule
`default_nettype wire

// ==== verification/adc_host_parallel_port_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module adc_host_parallel_port_tb_top;
	logic mclk_in = 1'b0;
	logic rst_n = 1'b0;
	logic ext_mode = 1'b0;
	logic cmp = 1'b0;
	logic [11:0] pat = 12'h000;
	logic [2:0] ext_cnt = 3'h0;
	int errors = 0;
	int checks = 0;
	int n;
	logic [7:0] d, oe, idle, data, oe_n;
	logic busy_n, cs_n, wr_n, rd_n, bs, alo, ahi;
	logic [1:0] chan;
	initial forever #20 mclk_in = ~mclk_in;
	// slow external conversion clock, stepped off the sampling edge
	always @(negedge mclk_in) ext_cnt <= ext_cnt + 3'h1;
	// comparator stand-in: a mixed pattern exposes any bit misplacement
	always @(negedge mclk_in) begin
		if (ahp_top_i.st_ff.bitn <= 4'hb) begin
			cmp <= pat[ahp_top_i.st_ff.bitn];
		end else begin
			cmp <= 1'b0;
		end
	end
	ahp_top #(.AZ_CYC(5), .OSC_DIV(2)) ahp_top_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n), .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
		.byte_half_select_in(bs), .channel_addr_lo_in(alo),
		.channel_addr_hi_in(ahi), .ext_clk_mode_in(ext_mode),
		.ext_clk_in(ext_cnt[2]), .cmp_hi_in(cmp), .data_out_bus_out(data),
		.data_out_bus_oe_n_out(oe_n), .busy_n_out(busy_n),
		.channel_sel_out(chan));
	// a released line shows the inverse of its last value
	ahp_host ahp_host_i (.mclk_in(mclk_in), .bus_in(data ^ oe_n),
		.oe_n_in(oe_n), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
		.byte_half_select_out(bs), .a_lo_out(alo), .a_hi_out(ahi));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_done(output int k);
		k = 0;
		while (busy_n !== 1'b1 && k < 2000) begin
			@(negedge mclk_in);
			k++;
		end
		if (k >= 2000) begin
			errors++;
			$display("[ERR] %0t conversion never ended", $time);
			results();
		end
	endtask
	initial begin
		repeat (10) @(negedge mclk_in);
		rst_n = 1'b1;
		@(negedge mclk_in);
		chk({7'h0, busy_n}, 8'h01);
		chk(oe_n, 8'hff);
		for (int c = 0; c < 4; c++) begin
			pat = 12'h9c3 ^ {3{c[3:0]}};
			ahp_host_i.conv(c[1:0], 1);
			chk({7'h0, busy_n}, 8'h00);
			ahp_host_i.rd(1'b1, d, oe, idle);
			chk(d, 8'h80);
			wait_done(n);
			chk({6'h0, chan}, c[7:0]);
			ahp_host_i.rd(1'b1, d, oe, idle);
			chk(d, {4'h0, pat[11:8]});
			chk(oe, 8'h00);
			chk(idle, 8'hff);
			ahp_host_i.rd(1'b0, d, oe, idle);
			chk(d, pat[7:0]);
		end
		ahp_host_i.conv(2'h1, 1);
		repeat (20) @(negedge mclk_in);
		ahp_host_i.conv(2'h3, 1);
		wait_done(n);
		chk({6'h0, chan}, 8'h03);
		ahp_host_i.rd(1'b0, d, oe, idle);
		chk(d, pat[7:0]);
		// loose window: oscillator phase at the strobe is not fixed
		chk({7'h0, n >= 49 && n <= 70}, 8'h01);
		ext_mode = 1'b1;
		pat = 12'h6b5;
		ahp_host_i.conv(2'h2, 12);
		wait_done(n);
		// 13 falls of an 8-cycle clock, plus phase and pipeline slack
		chk({7'h0, n >= 96 && n <= 112}, 8'h01);
		chk({6'h0, chan}, 8'h02);
		ahp_host_i.rd(1'b0, d, oe, idle);
		chk(d, 8'hb5);
		ahp_host_i.rd(1'b1, d, oe, idle);
		chk(d, 8'h06);
		results();
	end
	initial begin
		#(40 * 20000);
		errors++;
		results();
	end
endmodule
`default_nettype wire
